/* File: bench/dub_chk.sv */
module dub_chk
    import dub_pkg::*;
(
    // clock and reset
    input wire logic              core_clk_i,
    input wire logic              rst_n_i,
    // bus signals
    input wire logic [ADDR_W-1:0] reg_select,
    input wire logic              read_strobe_n,
    input wire logic              write_strobe_n,
    input wire logic              chan_a_select_n,
    input wire logic              chan_b_select_n,
    input wire logic [DATA_W-1:0] host_byte,
    input wire logic              host_byte_oe,
    input wire logic [DATA_W-1:0] dev_byte,
    input wire logic              dev_byte_oe,
    input wire logic              chan_a_irq_oe,
    input wire logic              chan_b_irq_oe,
    input wire logic              chan_a_out_port2_n,
    input wire logic              chan_b_out_port2_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] idle_r;
    logic [3:0] idle_nxt;
    logic       sel;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    // cycles since a selected read strobe was last low
    assign sel = !chan_a_select_n || !chan_b_select_n;
    always_comb begin
        idle_nxt = idle_r;
        if (!read_strobe_n && sel) idle_nxt = 4'h0;
        else if (idle_r != 4'hf) idle_nxt = idle_r + 4'h1;
    end
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) idle_r <= 4'hf;
        else idle_r <= idle_nxt;
    end
    property p_port2_a; chan_a_out_port2_n == !chan_a_irq_oe; endproperty
    a_port2_a: assert property (p_port2_a)
        else $error("chan a port2 and irq enable disagree");
    property p_port2_b; chan_b_out_port2_n == !chan_b_irq_oe; endproperty
    a_port2_b: assert property (p_port2_b)
        else $error("chan b port2 and irq enable disagree");
    property p_rd_drive; $fell(read_strobe_n) && sel |-> ##[1:5] dev_byte_oe;
    endproperty
    a_rd_drive: assert property (p_rd_drive)
        else $error("read byte not driven");
    property p_rd_hold;
        !read_strobe_n && dev_byte_oe && $past(dev_byte_oe) |-> $stable(dev_byte);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read byte changed under strobe");
    property p_quiet; dev_byte_oe |-> idle_r <= 4'h6; endproperty
    a_quiet: assert property (p_quiet)
        else $error("bus driven with no selected read");
    property p_one_drv; !(dev_byte_oe && host_byte_oe); endproperty
    a_one_drv: assert property (p_one_drv)
        else $error("both ends drive the bus");
    property p_one_sel; chan_a_select_n || chan_b_select_n; endproperty
    a_one_sel: assert property (p_one_sel)
        else $error("both channels selected");
    property p_addr;
        !read_strobe_n || !write_strobe_n |-> sel && $stable(reg_select);
    endproperty
    a_addr: assert property (p_addr)
        else $error("address or select moved under strobe");
    property p_wr_hold;
        $rose(write_strobe_n) |-> (host_byte_oe && $stable(host_byte)) [*3];
    endproperty
    a_wr_hold: assert property (p_wr_hold)
        else $error("write data not held after strobe");
    c_read: cover property ($fell(read_strobe_n) && !chan_b_select_n);
    c_irq_a: cover property ($rose(chan_a_irq_oe));
    c_irq_b: cover property ($rose(chan_b_irq_oe));
endmodule // dub_chk

/* File: bench/tb_dual_uart_host_bus_port.sv */
module tb_dual_uart_host_bus_port;
    import dub_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, v = 0, w = 0, cb = 0, rdy, rv, wp;
    logic [2:0] s = 3'h0;
    logic [7:0] d = 8'h00, rb, ra [NUM_REGS], rbr [NUM_REGS], e [2][8];
    logic [5:0] st = 6'h00;
    logic [7:0] rq[$];
    logic [11:0] wq[$];
    int bad_count = 0, checks = 0, seed;
    always #4 clk = ~clk;
    dub_bus_if bus_i ();
    dub_device dub_device_i (.core_clk_i(clk), .rst_n_i(rst_n), .bus(bus_i),
        .chan_a_irq_req_i(st[0]), .chan_b_irq_req_i(st[1]),
        .chan_a_tx_space_i(st[2]), .chan_a_rx_avail_i(st[3]),
        .chan_b_tx_space_i(st[4]), .chan_b_rx_avail_i(st[5]),
        .chan_a_regs_o(ra), .chan_b_regs_o(rbr), .wr_pulse_o(wp));
    dub_host dub_host_i (.core_clk_i(clk), .rst_n_i(rst_n), .bus(bus_i),
        .req_valid_i(v), .req_write_i(w), .req_chan_b_i(cb),
        .req_sel_i(s), .req_byte_i(d), .req_ready_o(rdy),
        .rsp_valid_o(rv), .rsp_byte_o(rb));
    dub_chk chk_i (.core_clk_i(clk), .rst_n_i(rst_n),
        .reg_select(bus_i.reg_select), .read_strobe_n(bus_i.read_strobe_n),
        .write_strobe_n(bus_i.write_strobe_n),
        .chan_a_select_n(bus_i.chan_a_select_n),
        .chan_b_select_n(bus_i.chan_b_select_n),
        .host_byte(bus_i.host_byte), .host_byte_oe(bus_i.host_byte_oe),
        .dev_byte(bus_i.dev_byte), .dev_byte_oe(bus_i.dev_byte_oe),
        .chan_a_irq_oe(bus_i.chan_a_irq_oe),
        .chan_b_irq_oe(bus_i.chan_b_irq_oe),
        .chan_a_out_port2_n(bus_i.chan_a_out_port2_n),
        .chan_b_out_port2_n(bus_i.chan_b_out_port2_n));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // host request; expectation noted before the request goes out
    task automatic req(input logic wr, input logic c, input logic [2:0] a,
                       input logic [7:0] b);
        int i;
        if (wr) begin
            e[c][a] = b;
            wq.push_back({c, a, b});
        end else rq.push_back(e[c][a]);
        @(posedge clk);
        v <= 1;  w <= wr;  cb <= c;  s <= a;  d <= b;
        for (i = 0; i < 40 && rdy !== 1'b1; i++) @(negedge clk);
        if (i == 40) begin
            bad_count++;
            give_verdict();
        end
        @(posedge clk);
        v <= 0;
    endtask
    task automatic drain();
        int i;
        for (i = 0; i < 60; i++) begin
            @(negedge clk);
            if (rq.size() == 0 && wq.size() == 0 && rdy === 1'b1) break;
        end
        if (i == 60) begin
            bad_count++;
            give_verdict();
        end
    endtask
    always @(negedge clk) if (rv === 1'b1 && rq.size() > 0)
        chk(rb, rq.pop_front());
    always @(negedge clk) if (wp === 1'b1 && wq.size() > 0) begin : wr_chk
        logic [11:0] n;
        n = wq.pop_front();
        chk(n[11] ? rbr[n[10:8]] : ra[n[10:8]], n[7:0]);
    end
    initial begin
        seed = $urandom(32'h4f06cbaa);
        repeat (5) @(posedge clk);
        rst_n <= 1;
        @(negedge clk);
        chk({bus_i.chan_a_out_port2_n, bus_i.chan_b_out_port2_n}, 8'h03);
        chk(ra[MODEM_CTRL_IDX] | rbr[MODEM_CTRL_IDX], REG_RESET);
        $display("test reset done");
        for (int k = 0; k < 16; k++)
            req(1, k[3], k[2:0], 8'($urandom) & ~8'h08);
        for (int k = 15; k >= 0; k--) req(0, k[3], k[2:0], 8'h00);
        drain();
        $display("test write and read done");
        for (int k = 0; k < 4; k++) begin
            req(1, k[0], MODEM_CTRL_IDX, k[1] ? 8'h00 : 8'h08);
            @(posedge clk) st <= 6'($urandom);
            drain();
            // bit 3 of a stays set over k 0..1, of b over k 1..2
            chk({bus_i.chan_a_irq_oe, bus_i.chan_a_out_port2_n},
                {k < 2, k >= 2});
            chk({bus_i.chan_b_irq_oe, bus_i.chan_b_out_port2_n},
                {k == 1 || k == 2, k == 0 || k == 3});
            if (k < 2) chk(k[0] ? bus_i.chan_b_irq
                : bus_i.chan_a_irq, st[k]);
        end
        $display("test irq gating done");
        repeat (8) begin
            @(posedge clk) st <= 6'($urandom);
            // ready pins are registered: one edge later
            repeat (2) @(negedge clk);
            chk(bus_i.chan_a_tx_ready_n, !st[2]);
            chk(bus_i.chan_a_rx_ready_n, !st[3]);
            chk(bus_i.chan_b_tx_ready_n, !st[4]);
            chk(bus_i.chan_b_rx_ready_n, !st[5]);
        end
        $display("test ready pins done");
        give_verdict();
    end
endmodule // tb_dual_uart_host_bus_port

/* File: core/dub_bus_if.sv */
interface dub_bus_if;
    import dub_pkg::*;
    logic [ADDR_W-1:0] reg_select;
    logic              read_strobe_n;
    logic              write_strobe_n;
    logic              chan_a_select_n;
    logic              chan_b_select_n;
    logic [DATA_W-1:0] host_byte;
    logic              host_byte_oe;
    logic [DATA_W-1:0] dev_byte;
    logic              dev_byte_oe;
    logic              chan_a_irq;
    logic              chan_a_irq_oe;
    logic              chan_b_irq;
    logic              chan_b_irq_oe;
    logic              chan_a_out_port2_n;
    logic              chan_b_out_port2_n;
    logic              chan_a_tx_ready_n;
    logic              chan_a_rx_ready_n;
    logic              chan_b_tx_ready_n;
    logic              chan_b_rx_ready_n;
    // resolved data bus level
    logic [DATA_W-1:0] bus_byte;
    assign bus_byte = host_byte_oe ? host_byte :
                      (dev_byte_oe ? dev_byte : {DATA_W{1'b1}});

    modport device (
        input  reg_select, read_strobe_n, write_strobe_n,
        input  chan_a_select_n, chan_b_select_n, bus_byte,
        output dev_byte, dev_byte_oe,
        output chan_a_irq, chan_a_irq_oe, chan_b_irq, chan_b_irq_oe,
        output chan_a_out_port2_n, chan_b_out_port2_n,
        output chan_a_tx_ready_n, chan_a_rx_ready_n,
        output chan_b_tx_ready_n, chan_b_rx_ready_n
    );
    modport host (
        output reg_select, read_strobe_n, write_strobe_n,
        output chan_a_select_n, chan_b_select_n,
        output host_byte, host_byte_oe,
        input  bus_byte,
        input  chan_a_irq, chan_a_irq_oe, chan_b_irq, chan_b_irq_oe,
        input  chan_a_out_port2_n, chan_b_out_port2_n,
        input  chan_a_tx_ready_n, chan_a_rx_ready_n,
        input  chan_b_tx_ready_n, chan_b_rx_ready_n
    );
endinterface

/* File: core/dub_device.sv */
// Operation
// R1: address lines choose register in channel
// R2: eight-bit two-way data bus
// R3: read strobe fall starts register read
// R4: byte held while read strobe low
// R5: write stored on write strobe rise
// R6: channel A active only while selected
// R7: channel B active only while selected
// R8: A bit3 set: drive irq, port2 low
// R9: A bit3 clear: irq floats, port2 high
// R10: B bit3 set: drive irq, port2 low
// R11: B bit3 clear: irq floats, port2 high
// R12: A tx ready low-active from tx status
// R13: A rx ready low-active from rx status
// R14: B tx ready low-active from tx status
// R15: B rx ready low-active from rx status
// R16: no select: strobes ignored, bus undriven
// R17: host never selects both channels
module dub_device
    import dub_pkg::*;
(
    // clock and reset
    input  wire logic              core_clk_i,
    input  wire logic              rst_n_i,
    // bus port
    dub_bus_if.device              bus,
    // user side: channel status from the uart cores
    input  wire logic              chan_a_irq_req_i,
    input  wire logic              chan_b_irq_req_i,
    input  wire logic              chan_a_tx_space_i,
    input  wire logic              chan_a_rx_avail_i,
    input  wire logic              chan_b_tx_space_i,
    input  wire logic              chan_b_rx_avail_i,
    // user side: register contents
    output logic [DATA_W-1:0]      chan_a_regs_o [NUM_REGS],
    output logic [DATA_W-1:0]      chan_b_regs_o [NUM_REGS],
    output logic                   wr_pulse_o
);
    // two-flop synchronisers for all pin inputs
    localparam int SW = ADDR_W + DATA_W + 4;
    logic [SW-1:0] s1_r, s2_r;
    logic [SW-1:0] s1_nxt;
    logic [ADDR_W-1:0] sel_s;
    logic [DATA_W-1:0] byte_s;
    logic rd_n_s, wr_n_s, csa_n_s, csb_n_s;

    always_comb begin
        s1_nxt = {bus.reg_select, bus.bus_byte, bus.read_strobe_n,
                  bus.write_strobe_n, bus.chan_a_select_n,
                  bus.chan_b_select_n};
    end
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_r <= '1;
            s2_r <= '1;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s1_r;
        end
    end
    assign {sel_s, byte_s, rd_n_s, wr_n_s, csa_n_s, csb_n_s} = s2_r;

    // channel registers, strobe edge state, read latch
    logic [DATA_W-1:0] rega_r [NUM_REGS];
    logic [DATA_W-1:0] regb_r [NUM_REGS];
    logic [DATA_W-1:0] rega_nxt [NUM_REGS];
    logic [DATA_W-1:0] regb_nxt [NUM_REGS];
    logic              rd_n_d_r, wr_n_d_r, rd_n_d_nxt, wr_n_d_nxt;
    logic [DATA_W-1:0] rd_byte_r, rd_byte_nxt;
    logic              rd_oe_r, rd_oe_nxt;
    logic              wr_pulse_r, wr_pulse_nxt;
    dub_chan_t         wr_ch_r, wr_ch_nxt;
    logic [ADDR_W-1:0] wr_sel_r, wr_sel_nxt;
    dub_chan_t         cur_ch;
    logic              wr_a_go, wr_b_go;

    always_comb begin
        cur_ch = DUB_CH_NONE;
        if (!csa_n_s)                              // R6
            cur_ch = DUB_CH_A;
        else if (!csb_n_s)                         // R7
            cur_ch = DUB_CH_B;
        wr_a_go      = 1'b0;
        wr_b_go      = 1'b0;
        rd_n_d_nxt   = rd_n_s;
        wr_n_d_nxt   = wr_n_s;
        rd_byte_nxt  = rd_byte_r;
        rd_oe_nxt    = rd_oe_r;
        wr_pulse_nxt = 1'b0;
        wr_ch_nxt    = wr_ch_r;
        wr_sel_nxt   = wr_sel_r;
        // falling read strobe fetches the addressed register
        if (rd_n_d_r && !rd_n_s && cur_ch != DUB_CH_NONE) begin // R3 R16
            rd_byte_nxt = (cur_ch == DUB_CH_A) ? rega_r[sel_s]
                                               : regb_r[sel_s]; // R1
            rd_oe_nxt   = 1'b1;
        end
        // drive only while strobe low and channel still selected
        if (rd_n_s || cur_ch == DUB_CH_NONE)                    // R4 R16
            rd_oe_nxt = 1'b0;
        // falling write strobe opens the cycle, rise commits it
        if (wr_n_d_r && !wr_n_s) begin                          // R5
            wr_ch_nxt  = cur_ch;
            wr_sel_nxt = sel_s;
        end
        if (!wr_n_s && cur_ch == DUB_CH_NONE)                   // R16
            wr_ch_nxt = DUB_CH_NONE;
        if (!wr_n_d_r && wr_n_s) begin                          // R5
            wr_a_go   = (wr_ch_r == DUB_CH_A);                  // R6
            wr_b_go   = (wr_ch_r == DUB_CH_B);                  // R7
            wr_ch_nxt = DUB_CH_NONE;
        end
        wr_pulse_nxt = wr_a_go || wr_b_go;
    end

    // register file: one write per committed strobe rise
    always_comb begin
        rega_nxt = rega_r;
        regb_nxt = regb_r;
        if (wr_a_go)                                            // R6
            rega_nxt[wr_sel_r] = byte_s;                        // R5
        if (wr_b_go)                                            // R7
            regb_nxt[wr_sel_r] = byte_s;                        // R5
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                rega_r[i] <= REG_RESET;
                regb_r[i] <= REG_RESET;
            end
        end else begin
            rega_r <= rega_nxt;
            regb_r <= regb_nxt;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_n_d_r   <= 1'b1;
            wr_n_d_r   <= 1'b1;
            rd_byte_r  <= REG_RESET;
            rd_oe_r    <= 1'b0;
            wr_pulse_r <= 1'b0;
            wr_ch_r    <= DUB_CH_NONE;
            wr_sel_r   <= '0;
        end else begin
            rd_n_d_r   <= rd_n_d_nxt;
            wr_n_d_r   <= wr_n_d_nxt;
            rd_byte_r  <= rd_byte_nxt;
            rd_oe_r    <= rd_oe_nxt;
            wr_pulse_r <= wr_pulse_nxt;
            wr_ch_r    <= wr_ch_nxt;
            wr_sel_r   <= wr_sel_nxt;
        end
    end

    // status pins come from flops; the gate bit is taken from the next
    // register value so that the pins move in the cycle of the write
    logic irq_a_r,      irq_a_nxt;
    logic irq_b_r,      irq_b_nxt;
    logic irq_oe_a_r,   irq_oe_a_nxt;
    logic irq_oe_b_r,   irq_oe_b_nxt;
    logic port2_a_n_r,  port2_a_n_nxt;
    logic port2_b_n_r,  port2_b_n_nxt;
    logic tx_rdy_a_n_r, tx_rdy_a_n_nxt;
    logic rx_rdy_a_n_r, rx_rdy_a_n_nxt;
    logic tx_rdy_b_n_r, tx_rdy_b_n_nxt;
    logic rx_rdy_b_n_r, rx_rdy_b_n_nxt;

    always_comb begin
        irq_a_nxt      = chan_a_irq_req_i;
        irq_b_nxt      = chan_b_irq_req_i;
        irq_oe_a_nxt   = rega_nxt[MODEM_CTRL_IDX][OUT2_BIT];     // R8 R9
        irq_oe_b_nxt   = regb_nxt[MODEM_CTRL_IDX][OUT2_BIT];     // R10 R11
        port2_a_n_nxt  = ~rega_nxt[MODEM_CTRL_IDX][OUT2_BIT];    // R8 R9
        port2_b_n_nxt  = ~regb_nxt[MODEM_CTRL_IDX][OUT2_BIT];    // R10 R11
        tx_rdy_a_n_nxt = ~chan_a_tx_space_i;                     // R12
        rx_rdy_a_n_nxt = ~chan_a_rx_avail_i;                     // R13
        tx_rdy_b_n_nxt = ~chan_b_tx_space_i;                     // R14
        rx_rdy_b_n_nxt = ~chan_b_rx_avail_i;                     // R15
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_a_r      <= 1'b0;
            irq_b_r      <= 1'b0;
            irq_oe_a_r   <= REG_RESET[OUT2_BIT];
            irq_oe_b_r   <= REG_RESET[OUT2_BIT];
            port2_a_n_r  <= ~REG_RESET[OUT2_BIT];
            port2_b_n_r  <= ~REG_RESET[OUT2_BIT];
            tx_rdy_a_n_r <= 1'b1;
            rx_rdy_a_n_r <= 1'b1;
            tx_rdy_b_n_r <= 1'b1;
            rx_rdy_b_n_r <= 1'b1;
        end else begin
            irq_a_r      <= irq_a_nxt;
            irq_b_r      <= irq_b_nxt;
            irq_oe_a_r   <= irq_oe_a_nxt;
            irq_oe_b_r   <= irq_oe_b_nxt;
            port2_a_n_r  <= port2_a_n_nxt;
            port2_b_n_r  <= port2_b_n_nxt;
            tx_rdy_a_n_r <= tx_rdy_a_n_nxt;
            rx_rdy_a_n_r <= rx_rdy_a_n_nxt;
            tx_rdy_b_n_r <= tx_rdy_b_n_nxt;
            rx_rdy_b_n_r <= rx_rdy_b_n_nxt;
        end
    end

    assign bus.dev_byte           = rd_byte_r;                // R2 R4
    assign bus.dev_byte_oe        = rd_oe_r;                  // R2 R16
    assign bus.chan_a_irq         = irq_a_r;
    assign bus.chan_a_irq_oe      = irq_oe_a_r;               // R8 R9
    assign bus.chan_a_out_port2_n = port2_a_n_r;              // R8 R9
    assign bus.chan_b_irq         = irq_b_r;
    assign bus.chan_b_irq_oe      = irq_oe_b_r;               // R10 R11
    assign bus.chan_b_out_port2_n = port2_b_n_r;              // R10 R11
    assign bus.chan_a_tx_ready_n  = tx_rdy_a_n_r;             // R12
    assign bus.chan_a_rx_ready_n  = rx_rdy_a_n_r;             // R13
    assign bus.chan_b_tx_ready_n  = tx_rdy_b_n_r;             // R14
    assign bus.chan_b_rx_ready_n  = rx_rdy_b_n_r;             // R15
    assign chan_a_regs_o          = rega_r;
    assign chan_b_regs_o          = regb_r;
    assign wr_pulse_o             = wr_pulse_r;
endmodule // dub_device

/* File: core/dub_host.sv */
module dub_host
    import dub_pkg::*;
(
    // clock and reset
    input  wire logic              core_clk_i,
    input  wire logic              rst_n_i,
    // bus port
    dub_bus_if.host                bus,
    // user side request
    input  wire logic              req_valid_i,
    input  wire logic              req_write_i,
    input  wire logic              req_chan_b_i,
    input  wire logic [ADDR_W-1:0] req_sel_i,
    input  wire logic [DATA_W-1:0] req_byte_i,
    output logic                   req_ready_o,
    // user side answer
    output logic                   rsp_valid_o,
    output logic [DATA_W-1:0]      rsp_byte_o
);
    logic [DATA_W-1:0] bus_s1_r, bus_s2_r;
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus_s1_r <= '0;
            bus_s2_r <= '0;
        end else begin
            bus_s1_r <= bus.bus_byte;
            bus_s2_r <= bus_s1_r;
        end
    end

    dub_hstate_t       st_r, st_nxt;
    logic [3:0]        cnt_r, cnt_nxt;
    logic              wr_r, wr_nxt, chb_r, chb_nxt;
    logic [ADDR_W-1:0] sel_r, sel_nxt;
    logic [DATA_W-1:0] byte_r, byte_nxt, rsp_r, rsp_nxt;
    logic              rv_r, rv_nxt;

    always_comb begin
        st_nxt   = st_r;
        cnt_nxt  = cnt_r;
        wr_nxt   = wr_r;
        chb_nxt  = chb_r;
        sel_nxt  = sel_r;
        byte_nxt = byte_r;
        rsp_nxt  = rsp_r;
        rv_nxt   = 1'b0;
        case (st_r)
            DUB_IDLE: begin
                if (req_valid_i) begin
                    wr_nxt   = req_write_i;
                    chb_nxt  = req_chan_b_i;
                    sel_nxt  = req_sel_i;
                    byte_nxt = req_byte_i;
                    cnt_nxt  = SETUP_CYC;
                    st_nxt   = DUB_WAIT;
                end
            end
            DUB_WAIT: begin
                cnt_nxt = cnt_r - 4'h1;
                if (cnt_r == 4'h1) begin
                    cnt_nxt = STROBE_CYC;
                    st_nxt  = DUB_STROBE;
                end
            end
            DUB_STROBE: begin
                cnt_nxt = cnt_r - 4'h1;
                // sample just before the rising edge of the strobe
                if (cnt_r == 4'h1) begin
                    if (!wr_r) begin
                        rsp_nxt = bus_s2_r;                    // R4
                        rv_nxt  = 1'b1;
                    end
                    cnt_nxt = HOLD_CYC;
                    st_nxt  = DUB_RELEASE;
                end
            end
            DUB_RELEASE: begin
                cnt_nxt = cnt_r - 4'h1;
                if (cnt_r == 4'h1)
                    st_nxt = DUB_IDLE;
            end
            default: st_nxt = DUB_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r   <= DUB_IDLE;
            cnt_r  <= '0;
            wr_r   <= 1'b0;
            chb_r  <= 1'b0;
            sel_r  <= '0;
            byte_r <= '0;
            rsp_r  <= '0;
            rv_r   <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            cnt_r  <= cnt_nxt;
            wr_r   <= wr_nxt;
            chb_r  <= chb_nxt;
            sel_r  <= sel_nxt;
            byte_r <= byte_nxt;
            rsp_r  <= rsp_nxt;
            rv_r   <= rv_nxt;
        end
    end

    logic active;
    assign active = (st_r != DUB_IDLE);
    assign bus.reg_select      = sel_r;                             // R1
    assign bus.chan_a_select_n = ~(active && !chb_r);               // R6 R17
    assign bus.chan_b_select_n = ~(active && chb_r);                // R7 R17
    assign bus.read_strobe_n   = ~(st_r == DUB_STROBE && !wr_r);    // R3
    assign bus.write_strobe_n  = ~(st_r == DUB_STROBE && wr_r);     // R5
    assign bus.host_byte       = byte_r;                            // R2
    assign bus.host_byte_oe    = active && wr_r;                    // R2 R5
    assign req_ready_o         = !active;
    assign rsp_valid_o         = rv_r;
    assign rsp_byte_o          = rsp_r;
endmodule // dub_host

/* File: core/dub_pkg.sv */
package dub_pkg;
    localparam int ADDR_W       = 3;
    localparam int DATA_W       = 8;
    localparam int NUM_REGS     = 8;
    // register index of the modem control register in each channel
    localparam logic [2:0] MODEM_CTRL_IDX = 3'h4;
    // bit of the modem control register that gates irq and out port 2
    localparam int OUT2_BIT     = 3;
    localparam logic [7:0] REG_RESET = 8'h00;
    // host strobe phase lengths in core clocks
    localparam logic [3:0] SETUP_CYC  = 4'h3;
    localparam logic [3:0] STROBE_CYC = 4'h8;
    localparam logic [3:0] HOLD_CYC   = 4'h3;
    typedef enum logic [1:0] {
        DUB_CH_NONE,
        DUB_CH_A,
        DUB_CH_B
    } dub_chan_t;
    typedef enum {
        DUB_IDLE,
        DUB_WAIT,
        DUB_STROBE,
        DUB_RELEASE
    } dub_hstate_t;
endpackage
